// ==== rtl/edsa_regs.vh ====
// Purpose: constants for the paged data window address unit
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   included by bare name
`ifndef EDSA_REGS_VH
`define EDSA_REGS_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define EDSA_OFF_RDPAGE   12'h000
`define EDSA_OFF_WRPAGE   12'h004
`define EDSA_OFF_STATUS   12'h008
`define EDSA_OFF_CLEAR    12'h00C
`define EDSA_OFF_ENABLE   12'h010
`define EDSA_OFF_TRAPADR  12'h014
// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define EDSA_PAGE_RST     10'h000
`define EDSA_PAGE_HI      9
`define EDSA_EA_TOP       15
`define EDSA_ST_TRAP      0
`define EDSA_ST_RDDONE    1
`define EDSA_ST_WRDONE    2
`define EDSA_ST_W         3
// ---------------------------------------------------------------
// timing counts in instruction cycles
// ---------------------------------------------------------------
`define EDSA_RD_CYC       2'h2
`define EDSA_RPT_CYC      2'h3
`define EDSA_RPT_FAST_CYC 2'h1
`endif

// ==== rtl/edsa_route.v ====
// Purpose: route a 24-bit paged address to ram, external port or program
// Assumes: page boundaries are module parameters
// Notes:   registered select outputs
`timescale 1ns/100ps
module edsa_route #(
  parameter [8:0] RAM_LAST_PAGE = 9'h001,
  parameter [8:0] EXT_LAST_PAGE = 9'h0FF
) (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // request
  input  wire        load,
  input  wire        is_prog,
  input  wire [23:0] addr,
  // routed address
  output reg  [23:0] out_addr,
  output reg         sel_ram,
  output reg         sel_ext,
  output reg         sel_prog
);
  // ---------------------------------------------------------------
  // route by page value
  // ---------------------------------------------------------------
  // program view pages override data decode since they are read only
  always @(posedge clk) begin
    if (!nrst) begin
      out_addr <= 24'h000000;
      sel_ram  <= 1'b0;
      sel_ext  <= 1'b0;
      sel_prog <= 1'b0;
    end else if (load) begin
      out_addr <= addr;
      sel_prog <= is_prog;
      sel_ram  <= !is_prog && (addr[23:15] <= RAM_LAST_PAGE);
      sel_ext  <= !is_prog && (addr[23:15] > RAM_LAST_PAGE) &&
                  (addr[23:15] <= EXT_LAST_PAGE);
    end else begin
      sel_ram  <= 1'b0;
      sel_ext  <= 1'b0;
      sel_prog <= 1'b0;
    end
  end
endmodule

// ==== rtl/edsa_top.v ====
// Purpose: address generation for the paged data window
// Assumes: core holds its request until done; apb for page registers
// Notes:   one clock, synchronous active low reset
`timescale 1ns/100ps
`include "edsa_regs.vh"
module edsa_top #(
  parameter [8:0] RAM_LAST_PAGE = 9'h001,
  parameter [8:0] EXT_LAST_PAGE = 9'h0FF
) (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // core access request
  input  wire        req,
  input  wire        req_write,
  input  wire [1:0]  req_size,
  input  wire        req_repeat,
  input  wire [15:0] effective_address,
  // core answer
  output wire        done,
  output reg         addr_error_trap,
  // memory side
  output wire [23:0] mem_addr,
  output reg         mem_double,
  output reg         mem_write,
  output reg  [1:0]  mem_size,
  output wire        sel_ram,
  output wire        sel_ext,
  output wire        sel_prog,
  output reg         sel_near,
  // interrupt
  output wire        irq
);
  // ---------------------------------------------------------------
  // state and declarations
  // ---------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_HI   = 2'h2;
  reg  [9:0]  read_page_select;
  reg  [9:0]  write_page_select;
  reg  [`EDSA_ST_W-1:0] status;
  reg  [`EDSA_ST_W-1:0] irq_enable;
  reg  [15:0] trap_addr;
  reg  [1:0]  state;
  reg  [1:0]  cnt;
  reg  [1:0]  rpt_seen;
  reg         in_rpt;
  reg         second;
  reg         route_load;
  reg         route_prog;
  reg  [23:0] route_addr;
  reg  [`EDSA_ST_W-1:0] set_ev;
  wire        wr_xfer;
  wire [`EDSA_ST_W-1:0] clr_bits;
  wire        paged;
  wire [9:0]  cur_page;
  wire        is_prog;
  wire        page_zero;
  wire        fin;
  wire        fast_rd;
  wire [23:0] route_out;
  reg  [15:0] near_addr;

  // address decode shared by read mux and write strobes
  function is_off;
    input [11:0] a;
    input [11:0] off;
    begin
      is_off = (a[11:2] == off[11:2]);
    end
  endfunction

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // zero wait states: every transfer completes in its access phase,
  // which keeps page changes cheap between bursts of paged accesses
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_xfer = psel && penable && pwrite;
  assign clr_bits = (wr_xfer && is_off(paddr, `EDSA_OFF_CLEAR) && pstrb[0])
                    ? pwdata[`EDSA_ST_W-1:0] : {`EDSA_ST_W{1'b0}};

  // page registers change only by software; pointer wrap never touches them
  always @(posedge clk) begin
    if (!nrst) begin
      read_page_select  <= `EDSA_PAGE_RST;
      write_page_select <= `EDSA_PAGE_RST;
      irq_enable        <= {`EDSA_ST_W{1'b0}};
    end else if (wr_xfer) begin
      if (is_off(paddr, `EDSA_OFF_RDPAGE)) begin
        if (pstrb[0]) read_page_select[7:0] <= pwdata[7:0];
        if (pstrb[1]) read_page_select[9:8] <= pwdata[9:8];
      end else if (is_off(paddr, `EDSA_OFF_WRPAGE)) begin
        if (pstrb[0]) write_page_select[7:0] <= pwdata[7:0];
        if (pstrb[1]) write_page_select[9:8] <= pwdata[9:8];
      end else if (is_off(paddr, `EDSA_OFF_ENABLE)) begin
        if (pstrb[0]) irq_enable <= pwdata[`EDSA_ST_W-1:0];
      end
    end
  end

  // read mux, unmapped reads as zero, clear register reads as zero
  always @* begin
    prdata = 32'h00000000;
    if (is_off(paddr, `EDSA_OFF_RDPAGE)) begin
      prdata[9:0] = read_page_select;
    end else if (is_off(paddr, `EDSA_OFF_WRPAGE)) begin
      prdata[9:0] = write_page_select;
    end else if (is_off(paddr, `EDSA_OFF_STATUS)) begin
      prdata[`EDSA_ST_W-1:0] = status;
    end else if (is_off(paddr, `EDSA_OFF_ENABLE)) begin
      prdata[`EDSA_ST_W-1:0] = irq_enable;
    end else if (is_off(paddr, `EDSA_OFF_TRAPADR)) begin
      prdata[15:0] = trap_addr;
    end
  end

  // ---------------------------------------------------------------
  // sticky status and interrupt
  // ---------------------------------------------------------------
  // set wins over clear so an event in the clearing cycle survives
  always @(posedge clk) begin
    if (!nrst) begin
      status <= {`EDSA_ST_W{1'b0}};
    end else begin
      status <= (status & ~clr_bits) | set_ev;
    end
  end
  assign irq = |(status & irq_enable);

  // ---------------------------------------------------------------
  // page selection and address forming
  // ---------------------------------------------------------------
  assign paged     = effective_address[`EDSA_EA_TOP];
  // writes use only the write page; reads and program view the read page
  assign cur_page  = req_write ? write_page_select : read_page_select;
  assign is_prog   = !req_write && read_page_select[`EDSA_PAGE_HI];
  assign page_zero = (cur_page[8:0] == 9'h000) && !is_prog;

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  // waits: paged read 2 cycles, repeated read 3,3 then 1; write 1
  // timing as seen by the core, counted from the taking cycle c0:
  //   near access, paged write, page-zero trap: done in c0
  //   paged read: done in c1, routed word shows in c1
  //   first two repeated reads: done in c2
  //   later repeated reads: done in c0, as fast as a write
  //   double word: second word follows one cycle after the first
  // done is combinational so the core can move on at the very edge
  // that finishes the access; a registered done would add a cycle to
  // every write and break the single-cycle promise
  assign fast_rd = !req_write && req_repeat && in_rpt &&
                   (rpt_seen == 2'h2);
  assign fin  = (state == ST_WAIT) && (cnt == 2'h1);
  assign done = (req && (state == ST_IDLE) &&
                (!paged || req_write || page_zero || fast_rd) &&
                !mem_double) || fin;

  always @* begin
    set_ev     = {`EDSA_ST_W{1'b0}};
    route_load = 1'b0;
    route_prog = is_prog;
    route_addr = {cur_page[8:0], effective_address[14:0]};
    if (req && paged && state == ST_IDLE) begin
      if (page_zero) begin
        set_ev[`EDSA_ST_TRAP] = 1'b1;
      end else begin
        route_load = 1'b1;
        if (req_write) set_ev[`EDSA_ST_WRDONE] = 1'b1;
        if (fast_rd) set_ev[`EDSA_ST_RDDONE] = 1'b1;
      end
    end
    if (second) begin
      route_load = 1'b1;
      route_addr = {route_out[23:1] + 23'h000001, route_out[0]};
      route_prog = sel_prog;
    end
    if (fin) set_ev[`EDSA_ST_RDDONE] = 1'b1;
  end

  always @(posedge clk) begin
    if (!nrst) begin
      state           <= ST_IDLE;
      cnt             <= 2'h0;
      rpt_seen        <= 2'h0;
      in_rpt          <= 1'b0;
      second          <= 1'b0;
      mem_double      <= 1'b0;
      mem_write       <= 1'b0;
      mem_size        <= 2'h0;
      sel_near        <= 1'b0;
      addr_error_trap <= 1'b0;
      trap_addr       <= 16'h0000;
      near_addr       <= 16'h0000;
    end else begin
      addr_error_trap <= set_ev[`EDSA_ST_TRAP];
      sel_near        <= req && !paged && state == ST_IDLE;
      second          <= 1'b0;
      if (!req_repeat) begin
        rpt_seen <= 2'h0;
        in_rpt   <= 1'b0;
      end
      if (set_ev[`EDSA_ST_TRAP]) trap_addr <= effective_address;
      // near address kept beside its select pulse, no page bits joined
      if (req && !paged && state == ST_IDLE) near_addr <= effective_address;
      case (state)
        ST_IDLE: begin
          if (req && paged && !page_zero) begin
            mem_write <= req_write;
            mem_size  <= req_size;
            // a double-word access drives a second word next cycle
            if (req_size == 2'h2) begin
              mem_double <= 1'b1;
              second     <= 1'b1;
              state      <= ST_HI;
            end
            // counts hold the cycles left after the taking cycle
            if (!req_write) begin
              if (req_repeat && rpt_seen < 2'h2) begin
                state    <= ST_WAIT;
                cnt      <= `EDSA_RPT_CYC - 2'h1;
                rpt_seen <= rpt_seen + 2'h1;
                in_rpt   <= 1'b1;
              end else if (fast_rd) begin
                // done already in the taking cycle; no wait state
                cnt <= `EDSA_RPT_FAST_CYC - 2'h1;
              end else begin
                state <= ST_WAIT;
                cnt   <= `EDSA_RD_CYC - 2'h1;
              end
            end
          end
        end
        ST_HI: begin
          mem_double <= 1'b0;
          state      <= ST_IDLE;
        end
        ST_WAIT: begin
          mem_double <= 1'b0;
          if (cnt == 2'h1) state <= ST_IDLE;
          else cnt <= cnt - 2'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // router
  // ---------------------------------------------------------------
  // near accesses bypass the router so no memory select is raised for
  // them; the lower space is reached directly with a zero page field
  // a small mux picks the near address while its select pulse stands
  assign mem_addr = sel_near ? {8'h00, near_addr} : route_out;

  edsa_route #(
    .RAM_LAST_PAGE (RAM_LAST_PAGE),
    .EXT_LAST_PAGE (EXT_LAST_PAGE)
  ) u_route (
    .clk      (clk),
    .nrst     (nrst),
    .load     (route_load),
    .is_prog  (route_prog),
    .addr     (route_addr),
    .out_addr (route_out),
    .sel_ram  (sel_ram),
    .sel_ext  (sel_ext),
    .sel_prog (sel_prog)
  );
endmodule

// ==== tb/edsa_top_asserts.sv ====
// Purpose: port checks for the paged window unit
// Assumes: one clock, synchronous active low reset
// Notes:   bound onto edsa_top, page limits passed on
`timescale 1ns/100ps
module edsa_chk #(
  parameter [8:0] RAM_LAST_PAGE = 9'h001,
  parameter [8:0] EXT_LAST_PAGE = 9'h0FF
) (
  // clock and reset
  input wire        clk,
  input wire        nrst,
  // core side
  input wire        req,
  input wire        req_write,
  input wire [1:0]  req_size,
  input wire [15:0] effective_address,
  input wire        done,
  input wire        addr_error_trap,
  // memory side
  input wire [23:0] mem_addr,
  input wire        mem_write,
  input wire        sel_ram,
  input wire        sel_ext,
  input wire        sel_prog,
  input wire        sel_near
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // page field of the routed address
  wire [8:0] pg = mem_addr[23:15];
  wire       new_req = req & ~done;

  chk_trap_nosel: assert property (addr_error_trap |-> !(sel_ram | sel_ext))
    else $error("trap with memory select");
  chk_trap_pulse: assert property (addr_error_trap |=> !addr_error_trap)
    else $error("trap longer than one cycle");
  chk_page_zero: assert property ((sel_ram | sel_ext) |-> pg != 9'h000)
    else $error("page zero routed");
  chk_sel_onehot: assert property ($onehot0({sel_ram, sel_ext, sel_prog, sel_near}))
    else $error("more than one select");
  chk_ram_page: assert property (sel_ram |-> pg <= RAM_LAST_PAGE)
    else $error("ram select outside ram pages");
  chk_ext_page: assert property (sel_ext |-> pg > RAM_LAST_PAGE && pg <= EXT_LAST_PAGE)
    else $error("external select outside its pages");
  chk_write_single: assert property ($rose(req) && req_write && req_size != 2'h2 |-> done)
    else $error("write not done in one cycle");
  chk_read_wait: assert property ($rose(req) && !req_write && effective_address[15] |-> !done or ##1 addr_error_trap)
    else $error("paged read done too soon");
  chk_near_route: assert property ($rose(req) && !effective_address[15] |=> sel_near)
    else $error("near access not routed near");
  chk_near_addr: assert property (sel_near |-> mem_addr[23:16] == 8'h00)
    else $error("near access carries page bits");
  chk_prog_read: assert property (sel_prog |-> !mem_write)
    else $error("write into program view");

  // main scenarios reached
  cov_trap: cover property ($rose(addr_error_trap));
  cov_ext_wr: cover property (sel_ext && mem_write);
  cov_prog: cover property (sel_prog);
  cov_near: cover property (sel_near);
endmodule

bind edsa_top edsa_chk #(.RAM_LAST_PAGE(RAM_LAST_PAGE),
  .EXT_LAST_PAGE(EXT_LAST_PAGE)) u_chk (.clk(clk), .nrst(nrst),
  .req(req), .req_write(req_write), .req_size(req_size),
  .effective_address(effective_address), .done(done),
  .addr_error_trap(addr_error_trap), .mem_addr(mem_addr),
  .mem_write(mem_write), .sel_ram(sel_ram), .sel_ext(sel_ext),
  .sel_prog(sel_prog), .sel_near(sel_near));

// ==== tb/edsa_core.sv ====
// Purpose: core model issuing effective addresses
// Assumes: request held until done, seen before the edge
// Notes:   plain loads and stores only, never read-modify-write
`timescale 1ns/100ps
module edsa_core (
  // clock and answer
  input  wire         clk,
  input  wire         done,
  // request
  output logic        req = 1'b0,
  output logic        req_write = 1'b0,
  output logic [1:0]  req_size = 2'h0,
  output logic        req_repeat = 1'b0,
  output logic [15:0] effective_address = 16'h0000
);
  // one access; called at a rising edge, returns at the taking edge
  task acc(input w, input [1:0] sz, input rp, input [14:0] off,
           input paged, output int cyc);
    req <= 1'b1;
    req_write <= w;
    req_size <= sz;
    req_repeat <= rp & ~w;
    effective_address <= {paged, off};
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (done !== 1'b1 && cyc < 50);
    @(posedge clk);
  endtask

  // drop the request and let routed outputs settle
  task rel;
    req <= 1'b0;
    req_repeat <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ==== tb/tb_edsa_top.sv ====
// Purpose: self-checking bench for the paged window unit
// Assumes: apb tasks reach the page registers, core model drives requests
// Notes:   routed outputs are captured at the edge before they change
`timescale 1ns/100ps
`include "edsa_regs.vh"
module tb_edsa_top;
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, d;
  logic [3:0]  pstrb = 4'hF, sel_seen = 0;
  logic [23:0] addr_seen = 0;
  wire  [31:0] prdata;
  wire  [23:0] mem_addr;
  wire  [15:0] effective_address;
  wire  [1:0]  req_size, mem_size;
  wire         pready, pslverr, req, req_write, req_repeat, done, trap;
  wire         irq, mem_double, mem_write, s_ram, s_ext, s_prog, s_near;
  int          n_fail = 0, total_checks = 0, n_sel = 0, n_trap = 0;
  int          cyc, i, n, tick = 0;

  edsa_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
    .req_write(req_write), .req_size(req_size), .req_repeat(req_repeat),
    .effective_address(effective_address), .done(done),
    .addr_error_trap(trap), .mem_addr(mem_addr), .mem_double(mem_double),
    .mem_write(mem_write), .mem_size(mem_size), .sel_ram(s_ram),
    .sel_ext(s_ext), .sel_prog(s_prog), .sel_near(s_near), .irq(irq));
  edsa_core core (.clk(clk), .done(done), .req(req), .req_write(req_write),
    .req_size(req_size), .req_repeat(req_repeat),
    .effective_address(effective_address));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task summarize;
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one apb transfer, entered at a rising edge
  task apb(input w, input [11:0] a, input [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task go(input w, input [1:0] sz, input [14:0] off, input paged);
    core.acc(w, sz, 1'b0, off, paged, cyc);
    core.rel();
  endtask

  // capture routed outputs; pre-edge values avoid racing the design
  always @(posedge clk) begin
    if (s_ram | s_ext | s_prog | s_near) begin
      sel_seen = {s_ram, s_ext, s_prog, s_near};
      addr_seen = mem_addr;
    end
    if (s_ram | s_ext | s_prog) n_sel++;
    if (trap === 1'b1) n_trap++;
    tick++;
    if (tick == 20000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // reset values, unmapped words read zero
    for (i = 0; i < 9; i++) begin
      apb(1'b0, i * 4, 0);
      chk(d, 0);
    end
    apb(1'b1, `EDSA_OFF_ENABLE, 32'h1);
    apb(1'b1, `EDSA_OFF_RDPAGE, 32'h2);
    apb(1'b1, `EDSA_OFF_WRPAGE, 32'h3);
    go(1'b0, 2'h1, 15'h0800, 1'b1);
    chk(cyc, 2);
    chk(addr_seen, 24'h010800);
    chk(sel_seen, 4'h4);
    go(1'b0, 2'h0, 15'h0001, 1'b1);
    chk(addr_seen, 24'h010001);
    for (i = 0; i < 3; i++) begin
      n = n_sel;
      go(1'b1, i, 15'h0100, 1'b1);
      chk(n_sel - n, (i == 2) ? 2 : 1);
      chk(addr_seen, (i == 2) ? 24'h018102 : 24'h018100);
      if (i < 2) chk(cyc, 1);
    end
    go(1'b0, 2'h1, 15'h1234, 1'b0);
    chk(sel_seen, 4'h1);
    chk(addr_seen, 24'h001234);
    apb(1'b1, `EDSA_OFF_RDPAGE, 32'h1);
    go(1'b0, 2'h1, 15'h7FFE, 1'b1);
    chk(addr_seen, 24'h00FFFE);
    chk(sel_seen, 4'h8);
    go(1'b0, 2'h1, 15'h0000, 1'b1);
    chk(addr_seen, 24'h008000);
    apb(1'b0, `EDSA_OFF_RDPAGE, 0);
    chk(d, 1);
    // page bit 9 set selects the program view; write page set to zero
    apb(1'b1, `EDSA_OFF_RDPAGE, 32'h201);
    apb(1'b1, `EDSA_OFF_WRPAGE, 32'h0);
    go(1'b0, 2'h1, 15'h0004, 1'b1);
    chk(sel_seen, 4'h2);
    chk(n_trap, 0);
    apb(1'b0, `EDSA_OFF_STATUS, 0);
    chk(d, 32'h6);
    apb(1'b1, `EDSA_OFF_CLEAR, 32'h7);
    apb(1'b1, `EDSA_OFF_RDPAGE, 32'h0);
    go(1'b0, 2'h1, 15'h0010, 1'b1);
    chk(n_trap, 1);
    apb(1'b0, `EDSA_OFF_STATUS, 0);
    chk(d[0], 1);
    chk(irq, 1);
    apb(1'b0, `EDSA_OFF_TRAPADR, 0);
    chk(d, 32'h8010);
    apb(1'b1, `EDSA_OFF_ENABLE, 32'h0);
    chk(irq, 0);
    apb(1'b1, `EDSA_OFF_ENABLE, 32'h1);
    apb(1'b1, `EDSA_OFF_CLEAR, 32'h7);
    apb(1'b0, `EDSA_OFF_STATUS, 0);
    chk(d, 0);
    chk(irq, 0);
    go(1'b1, 2'h1, 15'h0020, 1'b1);
    chk(n_trap, 2);
    // repeated paged reads held back to back
    apb(1'b1, `EDSA_OFF_RDPAGE, 32'h2);
    for (i = 0; i < 3; i++) begin
      core.acc(1'b0, 2'h1, 1'b1, 15'h0200 + 2 * i, 1'b1, cyc);
      chk(cyc, (i < 2) ? 3 : 1);
    end
    core.rel();
    summarize();
  end
endmodule
